// file: rtl/pwmc_core.sv
// pwm counter register core: down counter, period reload, two compares, status, apb slave
// assumes a synchronous apb master on ref_clk; kill and fifo-full are pins from other clocks
//
// Functional notes
// - interrupt is OR of status flags enabled by the mask.
// - reading status clears the sticky flags.
// - sticky flags capture on the clock, hold, clear only on status read.
// - transparent flags follow their sources, never latch, not read-cleared.
// - terminal-count flag is sticky, set while terminal count is high.
// - compare flags sticky; direct, or registered copy two clocks late.
// - kill flag shows the live kill condition.
// - capture-full flag shows live fullness; zero just means not full.
// - with status configured out, no status hardware exists.
// - counter holds while software enable low, unless hardware-only enable.
// - three-bit field selects the first output's comparison.
// - second three-bit field selects the second output's comparison.
// - compare fields load defaults at init, stay writable afterwards.
// - period writes do not disturb counting; reload only at terminal count.
// - counter decrements by one each enabled clock.
// - counter readable any time without disturbing it.
// - each output compares counter with its compare register per mode.
// - period, compare, counter widths are 8 or 16 bits.
//
// Decided for this implementation: the register addresses and the APB slave port.
`timescale 1ns/1ps
module pwmc_core #(
	parameter int         WIDTH       = 16,
	parameter bit         USE_STATUS  = 1'b1,
	parameter bit         HW_ONLY_EN  = 1'b0,
	parameter bit         PL_VARIANT  = 1'b0,
	parameter logic [2:0] CM1_DEFAULT = 3'h0,
	parameter logic [2:0] CM2_DEFAULT = 3'h0,
	parameter logic [15:0] PERIOD_DEFAULT = 16'hffff,
	parameter logic [15:0] CMP1_DEFAULT   = 16'h7fff,
	parameter logic [15:0] CMP2_DEFAULT   = 16'h3fff
) (
	// clock and reset
	input  wire logic                    ref_clk,
	input  wire logic                    rst_n,
	input  wire logic                    clkEn,
	// apb
	input  wire pwmc_pkg::pwmc_apb_req_t apbReq,
	output pwmc_pkg::pwmc_apb_rsp_t      apbRsp,
	// hardware enable and external status sources
	input  wire logic                    hwEnable,
	input  wire logic                    killActive,
	input  wire logic                    captureQueueFull,
	// outputs
	output logic                         firstModulatedOutput,
	output logic                         secondModulatedOutput,
	output logic                         terminalCount,
	output logic                         interrupt
);

	// =====================================
	// elaboration check
	// refuse widths that the counter and the read mux cannot serve
	if (WIDTH != 8 && WIDTH != 16) begin : g_bad_width
		$error("pwmc_core: WIDTH must be 8 or 16");
	end

	// =====================================
	// pin synchronisers, three stages
	logic [2:0] killSync_r;
	logic [2:0] fullSync_r;
	logic [2:0] hwEnSync_r;
	logic       killLive_r;
	logic       fullLive_r;
	logic       hwEnLive_r;

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			killSync_r <= 3'h0;
			fullSync_r <= 3'h0;
			hwEnSync_r <= 3'h0;
		end else if (clkEn) begin
			killSync_r <= {killSync_r[1:0], killActive};
			fullSync_r <= {fullSync_r[1:0], captureQueueFull};
			hwEnSync_r <= {hwEnSync_r[1:0], hwEnable};
		end
	end

	// a change counts once the last two stages agree
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			killLive_r <= 1'b0;
			fullLive_r <= 1'b0;
			hwEnLive_r <= 1'b0;
		end else if (clkEn) begin
			if (killSync_r[1] == killSync_r[2]) killLive_r <= killSync_r[2];
			if (fullSync_r[1] == fullSync_r[2]) fullLive_r <= fullSync_r[2];
			if (hwEnSync_r[1] == hwEnSync_r[2]) hwEnLive_r <= hwEnSync_r[2];
		end
	end

	// =====================================
	// apb decode
	logic        apbWrite;
	logic        apbRead;
	logic        addrHit;
	logic [7:0]  addr;
	logic [31:0] wdata;

	assign addr     = apbReq.paddr;
	assign wdata    = apbReq.pwdata;
	assign apbWrite = apbReq.psel && apbReq.penable && apbReq.pwrite;
	assign apbRead  = apbReq.psel && apbReq.penable && !apbReq.pwrite;

	always_comb begin
		unique case (addr)
			pwmc_pkg::OFF_CONTROL, pwmc_pkg::OFF_PERIOD, pwmc_pkg::OFF_CMP1,
			pwmc_pkg::OFF_CMP2, pwmc_pkg::OFF_COUNT: addrHit = 1'b1;
			pwmc_pkg::OFF_STATUS, pwmc_pkg::OFF_SMODE,
			pwmc_pkg::OFF_IMASK:                     addrHit = USE_STATUS;
			default:                                 addrHit = 1'b0;
		endcase
	end

	// =====================================
	// control, period, compare registers
	logic [7:0]       ctrl_r;
	logic [WIDTH-1:0] period_r;
	logic [WIDTH-1:0] cmp1_r;
	logic [WIDTH-1:0] cmp2_r;
	logic             swEnable;
	logic [2:0]       cm1Sel;
	logic [2:0]       cm2Sel;

	assign swEnable = ctrl_r[pwmc_pkg::CTRL_EN_BIT];
	assign cm1Sel   = ctrl_r[pwmc_pkg::CTRL_CM1_LSB +: pwmc_pkg::CM_W];
	assign cm2Sel   = ctrl_r[pwmc_pkg::CTRL_CM2_LSB +: pwmc_pkg::CM_W];

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			ctrl_r <= pwmc_pkg::CTRL_RST;
			ctrl_r[pwmc_pkg::CTRL_CM1_LSB +: pwmc_pkg::CM_W] <= CM1_DEFAULT;
			ctrl_r[pwmc_pkg::CTRL_CM2_LSB +: pwmc_pkg::CM_W] <= CM2_DEFAULT;
		end else if (clkEn && apbWrite && addr == pwmc_pkg::OFF_CONTROL) begin
			ctrl_r <= wdata[7:0];
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			period_r <= PERIOD_DEFAULT[WIDTH-1:0];
			cmp1_r   <= CMP1_DEFAULT[WIDTH-1:0];
			cmp2_r   <= CMP2_DEFAULT[WIDTH-1:0];
		end else if (clkEn && apbWrite) begin
			if (addr == pwmc_pkg::OFF_PERIOD) period_r <= wdata[WIDTH-1:0];
			if (addr == pwmc_pkg::OFF_CMP1)   cmp1_r   <= wdata[WIDTH-1:0];
			if (addr == pwmc_pkg::OFF_CMP2)   cmp2_r   <= wdata[WIDTH-1:0];
		end
	end

	// =====================================
	// period counter
	logic [WIDTH-1:0] count_r;
	logic             runEnable;
	logic             atZero;

	// hardware-only ignores the software bit; other modes use the software bit alone
	assign runEnable = HW_ONLY_EN ? hwEnLive_r : swEnable;
	assign atZero    = (count_r == '0);

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			count_r <= PERIOD_DEFAULT[WIDTH-1:0];
		end else if (clkEn && runEnable) begin
			if (atZero) begin
				count_r <= period_r;
			end else begin
				count_r <= count_r - 1'b1;
			end
		end
	end

	assign terminalCount = atZero && runEnable && clkEn;

	// =====================================
	// compare outputs
	logic match1;
	logic match2;

	pwmc_compare #(
		.WIDTH (WIDTH)
	) u_cmp1 (
		.count  (count_r),
		.cmpVal (cmp1_r),
		.mode   (cm1Sel),
		.match  (match1)
	);

	pwmc_compare #(
		.WIDTH (WIDTH)
	) u_cmp2 (
		.count  (count_r),
		.cmpVal (cmp2_r),
		.mode   (cm2Sel),
		.match  (match2)
	);

	// outputs registered to keep them glitch free
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			firstModulatedOutput  <= 1'b0;
			secondModulatedOutput <= 1'b0;
		end else if (clkEn) begin
			firstModulatedOutput  <= match1;
			secondModulatedOutput <= match2;
		end
	end

	// =====================================
	// status and interrupt
	logic [7:0] statusRead;
	logic [7:0] smode_r;
	logic [7:0] imask_r;
	logic       statusRdStb;

	assign statusRdStb = clkEn && apbRead && addr == pwmc_pkg::OFF_STATUS;

	generate
		if (USE_STATUS) begin : g_status
			logic [7:0] sticky_r;
			logic [7:0] srcs;
			logic [7:0] cmpPipe_r;
			logic       cmp1Src;
			logic       cmp2Src;

			// programmable-logic variant sees the registered output, one clock more
			always_ff @(posedge ref_clk) begin
				if (!rst_n) begin
					cmpPipe_r <= 8'h00;
				end else if (clkEn) begin
					cmpPipe_r <= {6'h00, secondModulatedOutput, firstModulatedOutput};
				end
			end
			assign cmp1Src = PL_VARIANT ? cmpPipe_r[0] : match1;
			assign cmp2Src = PL_VARIANT ? cmpPipe_r[1] : match2;

			always_comb begin
				srcs = 8'h00;
				srcs[pwmc_pkg::ST_TC]   = terminalCount;
				srcs[pwmc_pkg::ST_CMP1] = cmp1Src;
				srcs[pwmc_pkg::ST_CMP2] = cmp2Src;
				srcs[pwmc_pkg::ST_KILL] = killLive_r;
				srcs[pwmc_pkg::ST_FULL] = fullLive_r;
			end

			// set wins over the read clear
			always_ff @(posedge ref_clk) begin
				if (!rst_n) begin
					sticky_r <= 8'h00;
				end else if (clkEn) begin
					sticky_r <= ((statusRdStb ? 8'h00 : sticky_r) | srcs) & smode_r;
				end
			end

			always_ff @(posedge ref_clk) begin
				if (!rst_n) begin
					smode_r <= pwmc_pkg::SMODE_RST;
					imask_r <= pwmc_pkg::IMASK_RST;
				end else if (clkEn && apbWrite) begin
					if (addr == pwmc_pkg::OFF_SMODE) smode_r <= wdata[7:0];
					if (addr == pwmc_pkg::OFF_IMASK) imask_r <= wdata[7:0];
				end
			end

			assign statusRead = (sticky_r & smode_r) | (srcs & ~smode_r);
			assign interrupt  = |(statusRead & imask_r);

			tc_sticky_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
				clkEn && terminalCount && smode_r[pwmc_pkg::ST_TC] && !statusRdStb
				|=> sticky_r[pwmc_pkg::ST_TC])
				else $error("tc flag not captured");
			sticky_hold_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
				clkEn && !statusRdStb && (sticky_r & smode_r) != 8'h00 && $stable(smode_r)
				|=> (sticky_r & $past(sticky_r)) == $past(sticky_r))
				else $error("sticky flag dropped without read");
			read_clear_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
				statusRdStb && srcs == 8'h00 ##1 $stable(smode_r) |-> sticky_r == 8'h00)
				else $error("read did not clear sticky flags");
			kill_live_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
				!smode_r[pwmc_pkg::ST_KILL] |->
				statusRead[pwmc_pkg::ST_KILL] == killLive_r)
				else $error("kill flag not live");
			irq_or_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
				(imask_r & smode_r & sticky_r) != 8'h00 |-> interrupt)
				else $error("masked flag raised no interrupt");
			cmp_delay_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
				PL_VARIANT && clkEn && match1 ##1 clkEn |=> cmp1Src)
				else $error("compare flag source not two clocks late");
		end else begin : g_nostatus
			// no status hardware at all
			assign statusRead = 8'h00;
			assign smode_r    = 8'h00;
			assign imask_r    = 8'h00;
			assign interrupt  = 1'b0;
		end
	endgenerate

	// =====================================
	// read mux and response
	logic [31:0] rdata;

	always_comb begin
		rdata = 32'h0000_0000;
		unique case (addr)
			pwmc_pkg::OFF_STATUS:  rdata[7:0]       = statusRead;
			pwmc_pkg::OFF_CONTROL: rdata[7:0]       = ctrl_r;
			pwmc_pkg::OFF_PERIOD:  rdata[WIDTH-1:0] = period_r;
			pwmc_pkg::OFF_CMP1:    rdata[WIDTH-1:0] = cmp1_r;
			pwmc_pkg::OFF_CMP2:    rdata[WIDTH-1:0] = cmp2_r;
			pwmc_pkg::OFF_COUNT:   rdata[WIDTH-1:0] = count_r;
			pwmc_pkg::OFF_SMODE:   rdata[7:0]       = smode_r;
			pwmc_pkg::OFF_IMASK:   rdata[7:0]       = imask_r;
			default:               rdata            = 32'h0000_0000;
		endcase
	end

	// zero wait states; clkEn low stalls the bus so nothing is missed
	assign apbRsp.pready  = clkEn;
	assign apbRsp.pslverr = apbReq.psel && apbReq.penable && !addrHit;
	assign apbRsp.prdata  = addrHit ? rdata : 32'h0000_0000;

	// =====================================
	// checks
	hold_off_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		!HW_ONLY_EN && !swEnable && clkEn ##1 1'b1 |-> $stable(count_r))
		else $error("counter moved while disabled");
	decrement_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		clkEn && runEnable && !atZero |=> count_r == $past(count_r) - 1'b1)
		else $error("counter did not step by one");
	reload_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		terminalCount |=> count_r == $past(period_r))
		else $error("no reload at terminal count");
	period_iso_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		clkEn && apbWrite && addr == pwmc_pkg::OFF_PERIOD && runEnable && !atZero
		|=> count_r == $past(count_r) - 1'b1)
		else $error("period write disturbed counter");
	ctrl_back_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		clkEn && apbWrite && addr == pwmc_pkg::OFF_CONTROL
		|=> ctrl_r == $past(wdata[7:0]))
		else $error("control not read back as written");
	out_cmp_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		clkEn |=> firstModulatedOutput == $past(match1))
		else $error("first output not from compare");

endmodule

// file: shared/pwmc_pkg.sv
// package for the pwm counter register core: offsets, fields, compare codes, carriers
// assumes a 32-bit apb with byte addresses, one aligned word per register
package pwmc_pkg;

	// =====================================
	// register byte offsets
	localparam logic [7:0] OFF_STATUS  = 8'h00;
	localparam logic [7:0] OFF_CONTROL = 8'h04;
	localparam logic [7:0] OFF_PERIOD  = 8'h08;
	localparam logic [7:0] OFF_CMP1    = 8'h0c;
	localparam logic [7:0] OFF_CMP2    = 8'h10;
	localparam logic [7:0] OFF_COUNT   = 8'h14;
	localparam logic [7:0] OFF_SMODE   = 8'h18;
	localparam logic [7:0] OFF_IMASK   = 8'h1c;

	// =====================================
	// control fields
	localparam int CTRL_EN_BIT   = 0;
	localparam int CTRL_CM1_LSB  = 1;
	localparam int CTRL_CM2_LSB  = 4;
	localparam int CM_W          = 3;

	// =====================================
	// status bit positions
	localparam int ST_TC   = 0;
	localparam int ST_CMP1 = 1;
	localparam int ST_CMP2 = 2;
	localparam int ST_KILL = 3;
	localparam int ST_FULL = 4;
	localparam int ST_W    = 8;

	// sticky mode default: tc, cmp1, cmp2 sticky; kill, full transparent
	localparam logic [7:0] SMODE_RST = 8'h07;
	localparam logic [7:0] IMASK_RST = 8'h00;
	localparam logic [7:0] CTRL_RST  = 8'h00;

	// =====================================
	// compare codes
	typedef enum logic [2:0] {
		CM_LT = 3'h0,
		CM_LE = 3'h1,
		CM_EQ = 3'h2,
		CM_GT = 3'h3,
		CM_GE = 3'h4
	} pwmc_cm_t;

	// =====================================
	// apb carriers
	typedef struct packed {
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [7:0]  paddr;
		logic [31:0] pwdata;
	} pwmc_apb_req_t;

	typedef struct packed {
		logic        pready;
		logic        pslverr;
		logic [31:0] prdata;
	} pwmc_apb_rsp_t;

endpackage

// file: rtl/pwmc_compare.sv
// one compare unit: counter against compare value under a selectable relation
// assumes both operands on the same clock
`timescale 1ns/1ps
module pwmc_compare #(
	parameter int WIDTH = 16
) (
	// operands
	input  wire logic [WIDTH-1:0] count,
	input  wire logic [WIDTH-1:0] cmpVal,
	input  wire logic [2:0]       mode,
	// result
	output logic                  match
);

	always_comb begin
		unique case (mode)
			pwmc_pkg::CM_LE: match = (count <= cmpVal);
			pwmc_pkg::CM_EQ: match = (count == cmpVal);
			pwmc_pkg::CM_GT: match = (count > cmpVal);
			pwmc_pkg::CM_GE: match = (count >= cmpVal);
			default:         match = (count < cmpVal);
		endcase
	end

endmodule

// file: testbench/pwmc_core_tb_top.sv
// testbench for the pwm counter register core: registers, counting, compares, status flags
// assumes a zero-wait apb slave and software enable mode; clkEn is dropped once
`timescale 1ns/1ps
module pwmc_core_tb_top;
	// =====================================
	// small period so whole periods fit in short waits
	localparam logic [15:0] PER = 16'h0009;

	logic                    ref_clk          = 1'b0;
	logic                    rst_n            = 1'b0;
	logic                    clkEn            = 1'b1;
	logic                    hwEnable         = 1'b0;
	logic                    killActive       = 1'b0;
	logic                    captureQueueFull = 1'b0;
	pwmc_pkg::pwmc_apb_req_t apbReq           = '0;
	pwmc_pkg::pwmc_apb_rsp_t apbRsp;
	logic                    firstModulatedOutput;
	logic                    secondModulatedOutput;
	logic                    terminalCount;
	logic                    interrupt;
	int                      n_fail           = 0;
	int                      samples_checked  = 0;
	int                      cyc              = 0;
	int                      tcTimes[$];

	always #10 ref_clk = ~ref_clk;
	always @(posedge ref_clk) cyc <= cyc + 1;
	always @(negedge ref_clk) if (rst_n && terminalCount === 1'b1) tcTimes.push_back(cyc);

	pwmc_core #(
		.WIDTH(16), .CM1_DEFAULT(3'h2), .CM2_DEFAULT(3'h4), .PERIOD_DEFAULT(PER),
		.CMP1_DEFAULT(16'h0004), .CMP2_DEFAULT(16'h0006)
	) dut (
		.ref_clk(ref_clk), .rst_n(rst_n), .clkEn(clkEn), .apbReq(apbReq), .apbRsp(apbRsp),
		.hwEnable(hwEnable), .killActive(killActive), .captureQueueFull(captureQueueFull),
		.firstModulatedOutput(firstModulatedOutput), .secondModulatedOutput(secondModulatedOutput),
		.terminalCount(terminalCount), .interrupt(interrupt)
	);

	// =====================================
	// helpers
	task chk(input string what, input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			n_fail++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask

	task apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q, output logic err);
		apbReq.psel <= 1'b1;
		apbReq.penable <= 1'b0;
		apbReq.pwrite <= wr;
		apbReq.paddr <= a;
		apbReq.pwdata <= d;
		@(posedge ref_clk);
		apbReq.penable <= 1'b1;
		do @(posedge ref_clk); while (apbRsp.pready !== 1'b1);
		q = apbRsp.prdata;
		err = apbRsp.pslverr;
		apbReq.psel <= 1'b0;
		apbReq.penable <= 1'b0;
		// idle edge keeps psel from being driven twice in one step
		@(posedge ref_clk);
	endtask

	task wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		logic        e;
		apb(1'b1, a, d, q, e);
	endtask

	task rdc(input string what, input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] q;
		logic        e;
		apb(1'b0, a, 32'h0, q, e);
		chk(what, q, exp);
	endtask

	// returns at the reload edge, so the next bus call starts after a rising edge
	task wait_tc;
		int k;
		k = 0;
		do begin
			@(negedge ref_clk);
			k++;
		end while (k < 200 && terminalCount !== 1'b1);
		chk("tc seen", {31'h0, terminalCount}, 32'h1);
		@(posedge ref_clk);
	endtask

	function automatic int nhi(int m, int c);
		int k = 0;
		for (int v = 0; v <= 9; v++) begin
			case (m)
				1: k += int'(v <= c);
				2: k += int'(v == c);
				3: k += int'(v > c);
				4: k += int'(v >= c);
				default: k += int'(v < c);
			endcase
		end
		return k;
	endfunction

	// =====================================
	// scenarios
	task t_reset;
		logic [31:0] q;
		logic        e;
		rdc("control", pwmc_pkg::OFF_CONTROL, 32'h44);
		rdc("period", pwmc_pkg::OFF_PERIOD, 32'h9);
		rdc("cmp1", pwmc_pkg::OFF_CMP1, 32'h4);
		rdc("cmp2", pwmc_pkg::OFF_CMP2, 32'h6);
		rdc("smode", pwmc_pkg::OFF_SMODE, 32'h7);
		rdc("imask", pwmc_pkg::OFF_IMASK, 32'h0);
		wr(pwmc_pkg::OFF_COUNT, 32'h3);
		rdc("count held", pwmc_pkg::OFF_COUNT, 32'h9);
		wr(pwmc_pkg::OFF_CONTROL, 32'hffffffc4);
		rdc("control back", pwmc_pkg::OFF_CONTROL, 32'hc4);
		wr(pwmc_pkg::OFF_CONTROL, 32'h44);
		apb(1'b0, 8'h20, 32'h0, q, e);
		chk("unmapped err", {31'h0, e}, 32'h1);
		chk("unmapped data", q, 32'h0);
		$display("test reset done");
	endtask

	task t_count;
		logic [31:0] q1;
		logic [31:0] q2;
		logic        e;
		int          n;
		wr(pwmc_pkg::OFF_CONTROL, 32'h45);
		wait_tc;
		wait_tc;
		n = tcTimes.size();
		chk("tc spacing", 32'(tcTimes[n-1] - tcTimes[n-2]), 32'd10);
		@(negedge ref_clk);
		chk("tc width", {31'h0, terminalCount}, 32'h0);
		wait_tc;
		wr(pwmc_pkg::OFF_PERIOD, 32'h4);
		wait_tc;
		wait_tc;
		n = tcTimes.size();
		chk("old period", 32'(tcTimes[n-2] - tcTimes[n-3]), 32'd10);
		chk("new period", 32'(tcTimes[n-1] - tcTimes[n-2]), 32'd5);
		wr(pwmc_pkg::OFF_PERIOD, 32'h9);
		wait_tc;
		wait_tc;
		apb(1'b0, pwmc_pkg::OFF_COUNT, 32'h0, q1, e);
		apb(1'b0, pwmc_pkg::OFF_COUNT, 32'h0, q2, e);
		chk("count step", (q1 - q2 + 32'd10) % 32'd10, 32'd3);
		wr(pwmc_pkg::OFF_CONTROL, 32'h44);
		apb(1'b0, pwmc_pkg::OFF_COUNT, 32'h0, q1, e);
		apb(1'b0, pwmc_pkg::OFF_COUNT, 32'h0, q2, e);
		chk("count frozen", q2, q1);
		$display("test count done");
	endtask

	task t_clken;
		int n;
		wr(pwmc_pkg::OFF_CONTROL, 32'h45);
		wait_tc;
		// freeze right after the reload, so the counter must still hold the period
		clkEn <= 1'b0;
		n = tcTimes.size();
		repeat (25) @(posedge ref_clk);
		chk("tc frozen", 32'(tcTimes.size() - n), 32'd0);
		chk("pready stalled", {31'h0, apbRsp.pready}, 32'h0);
		clkEn <= 1'b1;
		rdc("count after freeze", pwmc_pkg::OFF_COUNT, 32'(PER) - 32'd1);
		$display("test clken done");
	endtask

	task t_compare;
		int h1;
		int h2;
		for (int m = 0; m < 8; m++) begin
			wr(pwmc_pkg::OFF_CONTROL, {25'h0, 3'(m), 3'(m), 1'b1});
			wait_tc;
			h1 = 0;
			h2 = 0;
			// a whole period sees every count once, so output lag does not matter
			repeat (10) begin
				@(negedge ref_clk);
				h1 += int'(firstModulatedOutput === 1'b1);
				h2 += int'(secondModulatedOutput === 1'b1);
			end
			chk("out1 highs", 32'(h1), 32'(nhi(m, 4)));
			chk("out2 highs", 32'(h2), 32'(nhi(m, 6)));
			@(posedge ref_clk);
		end
		$display("test compare done");
	endtask

	task t_status;
		wr(pwmc_pkg::OFF_CMP1, 32'hff);
		wr(pwmc_pkg::OFF_CMP2, 32'hff);
		wr(pwmc_pkg::OFF_CONTROL, 32'h24);
		wr(pwmc_pkg::OFF_IMASK, 32'h1f);
		chk("irq sticky", {31'h0, interrupt}, 32'h1);
		rdc("status sticky", pwmc_pkg::OFF_STATUS, 32'h7);
		rdc("status cleared", pwmc_pkg::OFF_STATUS, 32'h0);
		chk("irq cleared", {31'h0, interrupt}, 32'h0);
		killActive <= 1'b1;
		repeat (6) @(posedge ref_clk);
		rdc("kill live", pwmc_pkg::OFF_STATUS, 32'h8);
		rdc("kill kept", pwmc_pkg::OFF_STATUS, 32'h8);
		killActive <= 1'b0;
		captureQueueFull <= 1'b1;
		repeat (6) @(posedge ref_clk);
		rdc("full live", pwmc_pkg::OFF_STATUS, 32'h10);
		wr(pwmc_pkg::OFF_IMASK, 32'h8);
		chk("irq masked", {31'h0, interrupt}, 32'h0);
		wr(pwmc_pkg::OFF_IMASK, 32'h10);
		chk("irq full", {31'h0, interrupt}, 32'h1);
		captureQueueFull <= 1'b0;
		wr(pwmc_pkg::OFF_SMODE, 32'h0f);
		killActive <= 1'b1;
		repeat (8) @(posedge ref_clk);
		killActive <= 1'b0;
		repeat (8) @(posedge ref_clk);
		rdc("kill latched", pwmc_pkg::OFF_STATUS, 32'h8);
		rdc("kill read clear", pwmc_pkg::OFF_STATUS, 32'h0);
		$display("test status done");
	endtask

	// =====================================
	// run control
	task complete_run;
		$display("checks %0d mismatches %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	initial begin
		repeat (6) @(posedge ref_clk);
		rst_n <= 1'b1;
		// hardware enable pin must not count outside hardware-only mode
		hwEnable <= 1'b1;
		t_reset;
		t_count;
		t_clken;
		t_compare;
		t_status;
		complete_run;
	end

	// whole sequence needs well under 2000 cycles
	initial begin
		repeat (20000) @(posedge ref_clk);
		n_fail++;
		$display("watchdog expired");
		complete_run;
	end
endmodule
